// file: hdl/sas_map.svh
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
`define SAS_OFS_CTRL_A 8'h00
`define SAS_OFS_CTRL_B 8'h04
`define SAS_OFS_RES_UP 8'h08
`define SAS_OFS_RES_LO 8'h0c
`define SAS_OFS_FLAG 8'h10
`define SAS_OFS_IEN 8'h14
`define SAS_OFS_IRQC 8'h18
`define SAS_OFS_FREF 8'h1c
`define SAS_A_ON 0
`define SAS_A_GO 1
`define SAS_A_CH 6:2
`define SAS_B_PREF 1:0
`define SAS_B_NREF 2
`define SAS_B_CLK 6:4
`define SAS_B_JUST 7
`define SAS_F_DONE 0
`define SAS_E_IEN 0
`define SAS_I_PERIPHERAL_IRQ_ENABLE 6
`define SAS_I_GIE 7
`define SAS_R_TRNG 4
`define SAS_R_TEMP_SENSOR_ENABLE 5
`define SAS_RST_BYTE 8'h00
`define SAS_CH_TEMP 5'h1d
`define SAS_PREF_4096 2'h3
`define SAS_HALF_SAMPLE 5'h03
`define SAS_HALF_TOTAL 5'h17
`define SAS_MSB 4'h9
`endif

// file: hdl/sas_pkg.sv
// types shared by the converter sequencer
package sas_pkg;
  typedef enum logic [2:0] {
    SAS_IDLE = 3'b001,
    SAS_SAMPLE = 3'b010,
    SAS_CONV = 3'b100
  } sas_state_e;
  typedef logic [9:0] sas_result_t;
endpackage

// file: hdl/sas_sequencer.sv
// successive-approximation converter sequencer with a classic wishbone register slave
// Contract
// - build a 10-bit result by successive approximation, store it at completion.
// - a conversion lasts eleven and a half bit periods, one bit per period.
// - clock select picks sysclk/2,/4,/8,/16,/32,/64 or the rc oscillator.
// - channel select routes one source to the sample-and-hold input.
// - fifteen sources: twelve pins, temperature, dac output, fixed reference.
// - channel code 29 routes the temperature sensor to the converter.
// - positive reference: pin, supply, fixed 2.048V, fixed 4.096V unless low-voltage.
// - negative reference: pin or ground.
// - done flag sets at the end of every conversion, enable or not.
// - hardware never clears the done flag; software clears it by writing.
// - interrupt request only while done flag and its enable are both set.
// - conversions run in sleep only with the rc oscillator selected.
// - an enabled interrupt in sleep wakes the core; next instruction runs first.
// - after wake, vector only when global and peripheral enables are set.
// - temperature sensor is powered only while its enable bit is set.
// - range bit set selects high range, clear selects low range.
// - start bit begins a conversion only if the converter was already on.
// - at completion clear start, set flag, load result together.
// - early clear of start by a write after sampling loads partial result, unresolved bits copy last resolved.
// - justify bit places the result left or right across the two registers.
`timescale 1ns/1ps
`include "sas_map.svh"

module sas_sequencer #(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rc_osc_i,
  input wire logic comp_i,
  input wire logic sleep_i,
  output logic [4:0] channel_o,
  output logic temp_route_o,
  output logic [1:0] pos_ref_o,
  output logic neg_ref_o,
  output logic temp_enable_o,
  output logic temp_range_o,
  output logic sample_o,
  output logic busy_o,
  output logic [9:0] trial_code_o,
  output logic irq_o,
  output logic wake_o,
  output logic vector_o
);
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] irqc_reg;
  logic [7:0] fref_reg;
  logic ien_reg;
  logic flag_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  sas_pkg::sas_result_t result_reg;
  sas_pkg::sas_result_t trial_reg;
  sas_pkg::sas_state_e state_reg;
  logic [4:0] div_reg;
  logic [4:0] half_reg;
  logic [3:0] idx_reg;
  logic last_bit_reg;
  logic any_res_reg;
  logic rc_s1, rc_s2, rc_s3, cmp_s1, cmp_s2;
  logic wr_fire, wr_a, lane0, rc_sel, half_tick, start, abort, finish, resolve;
  logic [4:0] half_lim;
  logic [7:0] res_up, res_lo;
  sas_pkg::sas_result_t partial;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: ack one cycle after the request, write lands at the ack edge
  assign wr_fire = cyc_i & stb_i & we_i & ack_reg;
  assign lane0 = sel_i[0];
  assign wr_a = wr_fire & lane0 & (adr_i == `SAS_OFS_CTRL_A);
  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_reg <= 1'b0;
    else ack_reg <= cyc_i & stb_i & ~ack_reg;
  end

  // justified views of the stored result
  always_comb begin
    if (ctrl_b_reg[`SAS_B_JUST]) begin
      res_up = result_reg[9:2];
      res_lo = {result_reg[1:0], 6'h00};
    end else begin
      res_up = {6'h00, result_reg[9:8]};
      res_lo = result_reg[7:0];
    end
  end

  // read data captured before ack; unmapped offsets read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_reg) begin
      case (adr_i)
        `SAS_OFS_CTRL_A: rdata_reg <= {24'h00_0000, 1'b0, ctrl_a_reg[6:0]};
        `SAS_OFS_CTRL_B: rdata_reg <= {24'h00_0000, ctrl_b_reg};
        `SAS_OFS_RES_UP: rdata_reg <= {24'h00_0000, res_up};
        `SAS_OFS_RES_LO: rdata_reg <= {24'h00_0000, res_lo};
        `SAS_OFS_FLAG: rdata_reg <= {31'h0000_0000, flag_reg};
        `SAS_OFS_IEN: rdata_reg <= {31'h0000_0000, ien_reg};
        `SAS_OFS_IRQC: rdata_reg <= {24'h00_0000, irqc_reg};
        `SAS_OFS_FREF: rdata_reg <= {24'h00_0000, fref_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register a: on, start and channel; hardware clears start
  assign start = wr_a & dat_i[`SAS_A_GO] & ctrl_a_reg[`SAS_A_ON] & dat_i[`SAS_A_ON]
    & (state_reg == sas_pkg::SAS_IDLE);
  assign abort = (state_reg != sas_pkg::SAS_IDLE)
    & ((wr_a & ~(dat_i[`SAS_A_GO] & dat_i[`SAS_A_ON])) | (sleep_i & ~rc_sel));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_reg <= `SAS_RST_BYTE;
    end else begin
      if (wr_a) begin
        ctrl_a_reg[`SAS_A_CH] <= dat_i[`SAS_A_CH];
        ctrl_a_reg[`SAS_A_ON] <= dat_i[`SAS_A_ON];
        ctrl_a_reg[`SAS_A_GO] <= start | ((state_reg != sas_pkg::SAS_IDLE) & ~abort);
      end
      if (finish | (abort & ~wr_a)) ctrl_a_reg[`SAS_A_GO] <= 1'b0;
    end
  end

  // remaining control registers; 4.096V choice is refused on low-voltage parts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_b_reg <= `SAS_RST_BYTE;
      irqc_reg <= `SAS_RST_BYTE;
      fref_reg <= `SAS_RST_BYTE;
      ien_reg <= 1'b0;
    end else if (wr_fire & lane0) begin
      case (adr_i)
        `SAS_OFS_CTRL_B: begin
          ctrl_b_reg[7:2] <= {dat_i[7:4], 1'b0, dat_i[2]};
          if (!(LOW_VOLTAGE && dat_i[`SAS_B_PREF] == `SAS_PREF_4096))
            ctrl_b_reg[`SAS_B_PREF] <= dat_i[`SAS_B_PREF];
        end
        `SAS_OFS_IEN: ien_reg <= dat_i[`SAS_E_IEN];
        `SAS_OFS_IRQC: irqc_reg <= {dat_i[7:6], 6'h00};
        `SAS_OFS_FREF: fref_reg <= {2'h0, dat_i[5:4], 4'h0};
        default: ien_reg <= ien_reg;
      endcase
    end
  end

  // done flag: only conversions set it, only a written zero clears it, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) flag_reg <= 1'b0;
    else if (finish) flag_reg <= 1'b1;
    else if (wr_fire & lane0 & (adr_i == `SAS_OFS_FLAG) & ~dat_i[`SAS_F_DONE])
      flag_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for the rc oscillator and the comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {rc_s1, rc_s2, rc_s3, cmp_s1, cmp_s2} <= 5'h00;
    end else begin
      rc_s1 <= rc_osc_i;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
      cmp_s1 <= comp_i;
      cmp_s2 <= cmp_s1;
    end
  end

  // half-bit-period limit per clock select; rc gives a half tick per edge
  assign rc_sel = &ctrl_b_reg[5:4];
  always_comb begin
    case (ctrl_b_reg[`SAS_B_CLK])
      3'b000: half_lim = 5'h00;
      3'b100: half_lim = 5'h01;
      3'b001: half_lim = 5'h03;
      3'b101: half_lim = 5'h07;
      3'b010: half_lim = 5'h0f;
      3'b110: half_lim = 5'h1f;
      default: half_lim = 5'h00;
    endcase
  end
  assign half_tick = rc_sel ? (rc_s2 ^ rc_s3) : (div_reg == half_lim);

  // divider restarts with each conversion so the first period is whole
  always_ff @(posedge clk_i) begin
    if (rst_i | start | half_tick) div_reg <= 5'h00;
    else div_reg <= div_reg + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence: 1.5 periods of sampling, then ten bit periods, msb first
  assign resolve = (state_reg == sas_pkg::SAS_CONV) & half_tick & ~half_reg[0];
  assign finish = resolve & (idx_reg == 4'h0) & ~abort;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= sas_pkg::SAS_IDLE;
      half_reg <= 5'h00;
    end else begin
      case (state_reg)
        sas_pkg::SAS_IDLE: begin
          half_reg <= 5'h00;
          if (start) state_reg <= sas_pkg::SAS_SAMPLE;
        end
        sas_pkg::SAS_SAMPLE: begin
          if (half_tick) half_reg <= half_reg + 5'h01;
          if (abort) state_reg <= sas_pkg::SAS_IDLE;
          else if (half_tick && half_reg == `SAS_HALF_SAMPLE - 5'h01)
            state_reg <= sas_pkg::SAS_CONV;
        end
        sas_pkg::SAS_CONV: begin
          if (half_tick) half_reg <= half_reg + 5'h01;
          if (abort | finish) state_reg <= sas_pkg::SAS_IDLE;
        end
        default: state_reg <= sas_pkg::SAS_IDLE;
      endcase
    end
  end

  // trial code: keep the bit when the comparator says input is at or above
  always_ff @(posedge clk_i) begin
    if (rst_i | start) begin
      trial_reg <= 10'h200;
      idx_reg <= `SAS_MSB;
      last_bit_reg <= 1'b0;
      any_res_reg <= 1'b0;
    end else if (resolve) begin
      trial_reg[idx_reg] <= cmp_s2;
      if (idx_reg != 4'h0) trial_reg[idx_reg - 4'h1] <= 1'b1;
      if (idx_reg != 4'h0) idx_reg <= idx_reg - 4'h1;
      last_bit_reg <= cmp_s2;
      any_res_reg <= 1'b1;
    end
  end

  // partial result: bits from the current one down copy the last resolved bit
  always_comb begin
    partial = trial_reg;
    for (int i = 0; i < 10; i++)
      if (i <= int'(idx_reg)) partial[i] = any_res_reg & last_bit_reg;
    for (int i = 0; i < 10; i++)
      if (i > int'(idx_reg)) partial[i] = trial_reg[i];
  end

  // result loads with the flag on completion, or partially when a write stops it after sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) result_reg <= 10'h000;
    else if (finish) result_reg <= {trial_reg[9:1], cmp_s2};
    else if (abort & wr_a & (state_reg == sas_pkg::SAS_CONV)) result_reg <= partial;
  end

  ////////////////////////////////////////////////////////////////////////
  // analog-side controls and core-side interrupt signals
  assign channel_o = ctrl_a_reg[`SAS_A_CH];
  assign temp_route_o = ctrl_a_reg[`SAS_A_CH] == `SAS_CH_TEMP;
  assign pos_ref_o = ctrl_b_reg[`SAS_B_PREF];
  assign neg_ref_o = ctrl_b_reg[`SAS_B_NREF];
  assign temp_enable_o = fref_reg[`SAS_R_TEMP_SENSOR_ENABLE];
  assign temp_range_o = fref_reg[`SAS_R_TEMP_SENSOR_ENABLE] & fref_reg[`SAS_R_TRNG];
  assign sample_o = state_reg == sas_pkg::SAS_SAMPLE;
  assign busy_o = ctrl_a_reg[`SAS_A_GO];
  assign trial_code_o = trial_reg;
  assign irq_o = flag_reg & ien_reg;
  // wake only; the core runs the instruction after sleep before any vector
  assign wake_o = sleep_i & irq_o;
  assign vector_o = ~sleep_i & irq_o & irqc_reg[`SAS_I_GIE] & irqc_reg[`SAS_I_PERIPHERAL_IRQ_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence conv_start_s;
    start ##1 sample_o;
  endsequence
  sequence conv_done_s;
    finish ##1 (flag_reg && !busy_o);
  endsequence

  start_needs_on_a: assert property (start |-> ctrl_a_reg[`SAS_A_ON])
    else $error("start taken while converter off");
  start_sample_a: assert property (start |-> conv_start_s)
    else $error("sampling did not follow start");
  done_update_a: assert property (finish |-> conv_done_s)
    else $error("completion did not set flag and clear start");
  flag_sticky_a: assert property ($fell(flag_reg) |-> $past(wr_fire))
    else $error("done flag cleared without a write");
  flag_set_wins_a: assert property (finish |=> flag_reg)
    else $error("done flag missed a completion");
  irq_gate_a: assert property (irq_o == (flag_reg && ien_reg))
    else $error("interrupt not gated by flag and enable");
  sleep_clock_a: assert property (sleep_i && !rc_sel |=> state_reg == sas_pkg::SAS_IDLE)
    else $error("conversion ran in sleep without rc clock");
  div_restart_a: assert property (start |=> div_reg == 5'h00)
    else $error("divider not restarted at start");
  bit_count_a: assert property (finish |-> half_reg == `SAS_HALF_TOTAL - 5'h01)
    else $error("conversion length wrong");
  temp_off_a: assert property (!fref_reg[`SAS_R_TEMP_SENSOR_ENABLE] |-> !temp_enable_o && !temp_range_o)
    else $error("sensor powered while disabled");
  lv_ref_a: assert property (LOW_VOLTAGE |-> pos_ref_o != `SAS_PREF_4096)
    else $error("4.096V reference on low-voltage part");
endmodule // sas_sequencer

// file: tb/sas_far_side.sv
// comparator and rc oscillator model standing behind the converter sequencer
`timescale 1ns/1ps
module sas_far_side (
  input wire logic [9:0] trial_i,
  input wire logic [9:0] level_i,
  output logic comp_o,
  output logic rc_osc_o
);
  // held input at or above the trial code answers high
  assign comp_o = (level_i >= trial_i);
  // free-running rc oscillator, phase unrelated to clk_i
  initial begin
    rc_osc_o = 1'b0;
  end
  always #317 rc_osc_o = ~rc_osc_o;
endmodule // sas_far_side

// file: tb/sas_sequencer_test.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`include "sas_map.svh"
module sas_sequencer_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0, dr, q, seed = 32'h3b198ee7;
  logic [9:0] level = 10'h000, trial, er;
  logic [9:0] expq[$];
  logic [2:0] cs_list[7] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011};
  logic ack, comp, rc, route, nref, ten, trng, samp, busy, irq, wake, vec;
  logic [4:0] chan;
  logic [1:0] pref;
  int mismatches = 0, comparisons = 0, cycles = 0, n, h;
  always #50 clk_i = ~clk_i;
  sas_sequencer sas_sequencer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack), .rc_osc_i(rc),
    .comp_i(comp), .sleep_i(sleep), .channel_o(chan), .temp_route_o(route), .pos_ref_o(pref),
    .neg_ref_o(nref), .temp_enable_o(ten), .temp_range_o(trng), .sample_o(samp),
    .busy_o(busy), .trial_code_o(trial), .irq_o(irq), .wake_o(wake), .vector_o(vec));
  sas_far_side sas_far_side_i (.trial_i(trial), .level_i(level), .comp_o(comp), .rc_osc_o(rc));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // classic single cycle; holds everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'h1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  // lets registered outputs settle before they are looked at
  task automatic pause;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one full conversion; the model queue holds the level the result must equal
  task automatic conv(input logic [2:0] cs, input logic ien);
    seed = lfsr(seed);
    // at /2 the bit period is shorter than the synced comparator path allows,
    // so a full-scale level keeps the comparator still and the result defined
    er = (cs == 3'b000) ? 10'h3ff : seed[9:0];
    level <= er;
    expq.push_back(er);
    wb(1'b1, `SAS_OFS_IEN, {31'h0, ien});
    wb(1'b1, `SAS_OFS_CTRL_B, {25'h0, cs, 4'h0});
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h05);
    repeat (8) @(posedge clk_i);
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h07);
    chk({31'h0, samp}, 32'h1, "sampling");
    sleep <= (cs[1:0] == 2'b11);
    n = 1;
    while (busy === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    h = 1 << (2 * cs[1:0] + cs[2]);
    if (cs[1:0] != 2'b11) begin
      chk(32'(n >= 23 * h && n <= 23 * h + 2), 32'h1, "length");
    end
    er = expq.pop_front();
    pause;
    chk({31'h0, irq}, {31'h0, ien}, "irq");
    chk({31'h0, samp}, 32'h0, "sampling over");
    chk({30'h0, wake, vec}, {30'h0, ien & sleep, 1'b0}, "wake");
    rd(`SAS_OFS_FLAG, 32'h1, "flag");
    rd(`SAS_OFS_CTRL_A, 32'h05, "start cleared");
    rd(`SAS_OFS_RES_UP, {30'h0, er[9:8]}, "right upper");
    rd(`SAS_OFS_RES_LO, {24'h0, er[7:0]}, "right lower");
    wb(1'b1, `SAS_OFS_CTRL_B, {24'h0, 1'b1, cs, 4'h0});
    rd(`SAS_OFS_RES_UP, {24'h0, er[9:2]}, "left upper");
    rd(`SAS_OFS_RES_LO, {24'h0, er[1:0], 6'h0}, "left lower");
    sleep <= 1'b0;
    wb(1'b1, `SAS_OFS_IRQC, 32'hc0);
    pause;
    chk({31'h0, vec}, {31'h0, ien}, "vector");
    wb(1'b1, `SAS_OFS_IRQC, 32'h0);
    wb(1'b1, `SAS_OFS_FLAG, 32'h1);
    rd(`SAS_OFS_FLAG, 32'h1, "flag kept");
    wb(1'b1, `SAS_OFS_FLAG, 32'h0);
    rd(`SAS_OFS_FLAG, 32'h0, "flag cleared");
    chk({31'h0, irq}, 32'h0, "irq off");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, well above the longest run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({22'h0, trial}, 32'h200, "trial reset");
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), 32'h0, "reset read");
    end
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h02);
    pause;
    chk({31'h0, busy}, 32'h0, "start while off");
    foreach (cs_list[i]) begin
      conv(cs_list[i], ~i[0]);
    end
    // abort before the first bit is resolved leaves an all-zero result
    wb(1'b1, `SAS_OFS_CTRL_B, 32'h60);
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h07);
    repeat (100) @(posedge clk_i);
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h05);
    pause;
    chk({31'h0, busy}, 32'h0, "abort");
    rd(`SAS_OFS_RES_UP, 32'h0, "abort upper");
    rd(`SAS_OFS_RES_LO, 32'h0, "abort lower");
    rd(`SAS_OFS_FLAG, 32'h0, "abort no flag");
    // stop after three resolved bits 1,0,1: the seven unresolved copy the last one
    level <= 10'h2c0;
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h07);
    repeat (317) @(posedge clk_i);
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h05);
    rd(`SAS_OFS_RES_UP, 32'h2, "partial upper");
    rd(`SAS_OFS_RES_LO, 32'hff, "partial lower");
    // sleep without the rc clock stops the conversion and loads nothing
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h07);
    repeat (100) @(posedge clk_i);
    sleep <= 1'b1;
    pause;
    chk({31'h0, busy}, 32'h0, "sleep abort");
    rd(`SAS_OFS_RES_LO, 32'hff, "sleep no load");
    rd(`SAS_OFS_FLAG, 32'h0, "sleep no flag");
    sleep <= 1'b0;
    wb(1'b1, `SAS_OFS_CTRL_A, 32'h75);
    wb(1'b1, `SAS_OFS_FREF, 32'h30);
    wb(1'b1, `SAS_OFS_CTRL_B, 32'h07);
    pause;
    chk({27'h0, chan}, 32'h1d, "channel");
    chk({31'h0, route}, 32'h1, "temp route");
    chk({30'h0, ten, trng}, 32'h3, "temp high");
    chk({29'h0, pref, nref}, 32'h7, "refs");
    wb(1'b1, `SAS_OFS_FREF, 32'h20);
    pause;
    chk({30'h0, ten, trng}, 32'h2, "temp low");
    wb(1'b1, `SAS_OFS_FREF, 32'h10);
    pause;
    chk({30'h0, ten, trng}, 32'h0, "temp off");
    give_verdict;
  end
endmodule // sas_sequencer_test
